// [bench/lower_timer_model.sv]
// Purpose: stand-in for the lower timer overflow and the count pin source
// Assumes: lower timer held in cascade mode, overflowing every 5 cycles
// Notes: pin rests low while idle; rising edge every 8 cycles when enabled
module lower_timer_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ovf_en,
   input wire logic i_pin_en,
   output logic o_overflow,
   output logic o_count_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int ovf_cnt;
   int pin_cnt;
   // a fixed five-cycle count paces the cascade tick
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ovf_cnt <= 0;
         pin_cnt <= 0;
         o_overflow <= 1'b0;
         o_count_pin <= 1'b0;
      end else begin
         ovf_cnt <= (ovf_cnt == 4) ? 0 : ovf_cnt + 1;
         pin_cnt <= (pin_cnt == 3) ? 0 : pin_cnt + 1;
         o_overflow <= i_ovf_en && (ovf_cnt == 4);
         o_count_pin <= i_pin_en && ((pin_cnt == 3) ? !o_count_pin : o_count_pin);
      end
   end
endmodule : lower_timer_model

// [bench/tb_upper_timer.sv]
// Purpose: self-checking bench for the upper timer
// Assumes: 10 MHz clock, low tick every 50 cycles
// Notes: hsize is tied; hready is the slave's own hreadyout
module tb_upper_timer
   import timer4_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [2:0] sel; logic presel; logic slow; logic [15:0] div;} row_type;
   row_type rows [14] = '{'{3'h0, 1'b0, 1'b0, 16'h0800}, '{3'h1, 1'b0, 1'b0, 16'h0080},
      '{3'h2, 1'b0, 1'b0, 16'h0020}, '{3'h3, 1'b0, 1'b0, 16'h0008}, '{3'h4, 1'b0, 1'b0, 16'h0032},
      '{3'h5, 1'b0, 1'b0, 16'h0002}, '{3'h6, 1'b0, 1'b0, 16'h0001}, '{3'h7, 1'b0, 1'b0, 16'h0008},
      '{3'h0, 1'b1, 1'b0, 16'h0190}, '{3'h0, 1'b0, 1'b1, 16'h0190}, '{3'h1, 1'b0, 1'b1, 16'h0000},
      '{3'h5, 1'b0, 1'b1, 16'h0000},
      '{3'h4, 1'b0, 1'b1, 16'h0032}, '{3'h7, 1'b0, 1'b1, 16'h0008}};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic presel = 1'b0;
   logic slow = 1'b0;
   logic lf_tick = 1'b0;
   logic ovf_en = 1'b0;
   logic pin_en = 1'b0;
   logic clk_en = 1'b1;
   logic [31:0] rd_first;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [1:0] hresp;
   logic hreadyout;
   logic irq;
   logic tout;
   logic ovf;
   logic pin;
   int fails = 0;
   int samples_checked = 0;
   int lf_cnt = 0;
   int n;
   int lim;
   control_type cur;
   control_type c;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      lf_cnt <= (lf_cnt == 49) ? 0 : lf_cnt + 1;
      lf_tick <= (lf_cnt == 49);
   end
   upper_timer dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_CLK_EN(clk_en), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
      .I_HWDATA(hwdata), .I_HREADY(hreadyout), .I_PRESCALER_SELECT(presel), .I_SLOW_MODE(slow),
      .I_LF_TICK(lf_tick), .I_COUNT_PIN(pin), .I_LOWER_OVERFLOW(ovf), .O_HRDATA(hrdata),
      .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_IRQ(irq), .O_TIMER_OUT(tout));
   lower_timer_model partner (.i_clk(clk), .i_rst_n(reset_n), .i_ovf_en(ovf_en),
      .i_pin_en(pin_en), .o_overflow(ovf), .o_count_pin(pin));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 20);
      rd = hrdata;
      if (k >= 20) begin
         fails++;
         print_verdict();
      end
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rdchk
   task automatic start(input control_type s);
      s.run = 1'b1;
      bus(1'b1, CONTROL_OFFSET, {24'h0, s});
      cur = s;
   endtask : start
   task automatic stop();
      cur.run = 1'b0;
      bus(1'b1, CONTROL_OFFSET, {24'h0, cur});
   endtask : stop
   task automatic wait_irq(input int b);
      for (n = 0; irq !== 1'b1 && n < b; n++) @(posedge clk);
   endtask : wait_irq
   task automatic wait_out(input int b);
      logic v;
      v = tout;
      for (n = 0; tout === v && n < b; n++) @(posedge clk);
      if (n >= b) check(32'(n), 32'h0);
   endtask : wait_out
   task automatic reset_check();
      rdchk(CONTROL_OFFSET, 32'h0);
      rdchk(PERIOD_OFFSET, 32'hFF);
      rdchk(PULSE_OFFSET, 32'hFF);
      rdchk(STATUS_OFFSET, 32'h0);
      rdchk(MASK_OFFSET, 32'h0);
      rdchk(COUNT_OFFSET, 32'h0);
      rdchk(8'h20, 32'h0);
      check({30'h0, irq, tout}, 32'h0);
   endtask : reset_check
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      cur = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      reset_check();
      pin_en <= 1'b1;
      bus(1'b1, PERIOD_OFFSET, 32'h1);
      bus(1'b1, MASK_OFFSET, 32'h1);
      foreach (rows[i]) begin
         presel <= rows[i].presel;
         slow <= rows[i].slow;
         c = '0;
         c.clk_sel = clock_select_type'(rows[i].sel);
         start(c);
         lim = (rows[i].div == 16'h0) ? 500 : 2 * rows[i].div + 20;
         wait_irq(lim);
         if (rows[i].div == 16'h0) check(32'(n), 32'(lim));
         else check(32'(n >= rows[i].div - 1 && n < lim), 32'h1);
         stop();
         rdchk(STATUS_OFFSET, {31'h0, rows[i].div != 16'h0});
      end
      presel <= 1'b0;
      slow <= 1'b0;
      c = '0;
      c.clk_sel = CLK_HF;
      c.mode = MODE_TIMER16;
      start(c);
      wait_irq(100);
      check(32'(n), 32'h64);
      ovf_en <= 1'b1;
      wait_irq(40);
      check(32'(n < 40), 32'h1);
      stop();
      rdchk(STATUS_OFFSET, 32'h1);
      bus(1'b1, MASK_OFFSET, 32'h0);
      c.mode = MODE_TIMER8;
      start(c);
      repeat (20) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, MASK_OFFSET, 32'h1);
      wait_irq(4);
      check(32'(n < 4), 32'h1);
      stop();
      rdchk(STATUS_OFFSET, 32'h1);
      repeat (20) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rdchk(STATUS_OFFSET, 32'h0);
      rdchk(COUNT_OFFSET, 32'h0);
      bus(1'b1, PERIOD_OFFSET, 32'h3);
      rdchk(PERIOD_OFFSET, 32'h3);
      c.mode = MODE_DIVIDER8;
      start(c);
      wait_out(40);
      wait_out(40);
      check(32'(n), 32'h4);
      stop();
      bus(1'b1, PULSE_OFFSET, 32'h40);
      rdchk(PULSE_OFFSET, 32'h40);
      c.mode = MODE_PWM8;
      start(c);
      wait_out(300);
      wait_out(300);
      check(32'(n), 32'hBF);
      stop();
      c.preset = 1'b1;
      start(c);
      @(posedge clk);
      check({31'h0, tout}, 32'h1);
      c.mode = MODE_TIMER8;
      stop();
      bus(1'b1, PERIOD_OFFSET, 32'hFE);
      c.preset = 1'b0;
      start(c);
      repeat (10) @(posedge clk);
      bus(1'b0, COUNT_OFFSET, 32'h0);
      check(32'(rd != 32'h0), 32'h1);
      // frozen cycles must not count: only the two enabled bus edges advance it
      rd_first = rd;
      clk_en <= 1'b0;
      repeat (10) @(posedge clk);
      clk_en <= 1'b1;
      bus(1'b0, COUNT_OFFSET, 32'h0);
      check(rd - rd_first, 32'h2);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      reset_check();
      print_verdict();
   end
endmodule : tb_upper_timer

// [bench/upper_timer_checker.sv]
// Purpose: port-level checks of the upper timer
// Assumes: whole-word control writes, one clock domain
// Notes: stop tracking follows the run bit seen on the bus
module upper_timer_checker
   import timer4_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_CLK_EN,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   input wire logic [31:0] O_HRDATA,
   input wire logic O_HREADYOUT,
   input wire logic [1:0] O_HRESP,
   input wire logic O_IRQ,
   input wire logic O_TIMER_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   logic taken;
   logic ap_rd;
   logic ap_wr;
   logic ap_ctl;
   logic stopped_reg;
   assign taken = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
   // ------------------------------------------------------------
   // bus phase tracking
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ap_rd <= 1'b0;
         ap_wr <= 1'b0;
         ap_ctl <= 1'b0;
         stopped_reg <= 1'b1;
      end else if (I_CLK_EN) begin
         ap_rd <= taken && !I_HWRITE;
         ap_wr <= taken && I_HWRITE;
         ap_ctl <= taken && I_HWRITE && (I_HADDR[7:0] == CONTROL_OFFSET);
         stopped_reg <= ap_ctl ? !I_HWDATA[3] : stopped_reg;
      end
   end
   AST_HREADY: assert property (O_HREADYOUT == 1'b1)
      else $error("hreadyout dropped");
   AST_HRESP: assert property (O_HRESP == HRESP_OKAY)
      else $error("response not okay");
   AST_HI_ZERO: assert property (O_HRDATA[31:8] == 24'h0)
      else $error("read data above byte not zero");
   AST_RD_IDLE: assert property (!ap_rd |-> O_HRDATA == 32'h0)
      else $error("read data outside data phase");
   AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> ap_rd || ap_wr || $past(ap_wr))
      else $error("irq fell without bus access");
   AST_STOP_IRQ: assert property (stopped_reg && !ap_wr && !$past(ap_wr) |-> !$rose(O_IRQ))
      else $error("irq rose while stopped");
   AST_STOP_OUT: assert property (stopped_reg && !ap_wr && !$past(ap_wr) |-> $stable(O_TIMER_OUT))
      else $error("output moved while stopped");
   AST_START_OUT: assert property (I_CLK_EN && ap_ctl && I_HWDATA[3] && stopped_reg
      |=> O_TIMER_OUT == $past(I_HWDATA[7]))
      else $error("start did not load preset");
   COV_IRQ: cover property ($rose(O_IRQ));
   COV_OUT: cover property ($rose(O_TIMER_OUT));
   COV_RD: cover property (ap_rd && O_HRDATA != 32'h0);
endmodule : upper_timer_checker
bind upper_timer upper_timer_checker chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
   .I_CLK_EN(I_CLK_EN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
   .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
   .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ), .O_TIMER_OUT(O_TIMER_OUT));

// [design/tick_select.sv]
// Purpose: picks the count tick of the upper timer from the clock taps
// Assumes: every tap is a one-cycle pulse in the system clock domain
// Notes: purely combinational; the caller registers what it needs
module tick_select
   import timer4_pkg::*;
(
   input wire clock_select_type i_sel,
   input wire logic i_prescaler_select,
   input wire logic i_slow,
   input wire taps_type i_taps,
   output logic o_tick
);

   always_comb begin
      o_tick = 1'b0;
      if (i_slow) begin
         // low clock and count pin only: fast taps are not running in slow/sleep
         case (i_sel)
            CLK_HF_2048: o_tick = i_taps.lf_8;
            CLK_LF: o_tick = i_taps.lf;
            CLK_PIN: o_tick = i_taps.pin;
            default: o_tick = 1'b0;
         endcase
      end else begin
         case (i_sel)
            CLK_HF_2048: o_tick = i_prescaler_select ? i_taps.lf_8 : i_taps.hf_2048;
            CLK_HF_128: o_tick = i_taps.hf_128;
            CLK_HF_32: o_tick = i_taps.hf_32;
            CLK_HF_8: o_tick = i_taps.hf_8;
            CLK_LF: o_tick = i_taps.lf;
            CLK_HF_2: o_tick = i_taps.hf_2;
            CLK_HF: o_tick = i_taps.hf;
            CLK_PIN: o_tick = i_taps.pin;
            default: o_tick = 1'b0;
         endcase
      end
   end

endmodule : tick_select

// [design/upper_timer.sv]
// Purpose: upper byte of a cascadable pair of 8-bit timer/counters
// Assumes: I_CLK is the high-frequency clock; I_LF_TICK marks low clock edges
// Notes: registers over AHB-Lite, zero wait states, always OKAY
module upper_timer
   import timer4_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_CLK_EN,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   input wire logic I_PRESCALER_SELECT,
   input wire logic I_SLOW_MODE,
   input wire logic I_LF_TICK,
   input wire logic I_COUNT_PIN,
   input wire logic I_LOWER_OVERFLOW,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic [1:0] O_HRESP,
   output logic O_IRQ,
   output logic O_TIMER_OUT
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   control_type control_reg, control_next;
   logic [7:0] period_reg, period_next;
   logic [7:0] pulse_reg, pulse_next;
   logic [7:0] pulse_shadow_reg, pulse_shadow_next;
   logic [7:0] count_reg, count_next;
   logic [STAT_WIDTH-1:0] status_reg, status_next;
   logic [STAT_WIDTH-1:0] mask_reg, mask_next;
   logic flop_reg, flop_next;
   logic irq_reg, irq_next;
   bus_phase_type phase_reg, phase_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [10:0] prescale_reg, prescale_next;
   logic [2:0] lf_div_reg, lf_div_next;
   logic pin_reg, pin_next;

   logic sel_tick;
   logic tick;
   logic running;
   logic take;
   logic status_read;
   logic [STAT_WIDTH-1:0] events;
   taps_type taps;

   // -------------------------------------------------------------------
   // clock taps and tick choice
   // -------------------------------------------------------------------
   always_comb begin
      prescale_next = prescale_reg + 11'h001;
      lf_div_next = I_LF_TICK ? lf_div_reg + 3'h1 : lf_div_reg;
      pin_next = I_COUNT_PIN;
      taps.hf_2048 = &prescale_reg[TAP_DIV2048-1:0];
      taps.hf_128 = &prescale_reg[TAP_DIV128-1:0];
      taps.hf_32 = &prescale_reg[TAP_DIV32-1:0];
      taps.hf_8 = &prescale_reg[TAP_DIV8-1:0];
      taps.hf_2 = prescale_reg[0];
      taps.hf = 1'b1;
      taps.lf = I_LF_TICK;
      taps.lf_8 = I_LF_TICK & (&lf_div_reg);
      // rising edge of the count pin; pin is synchronous to I_CLK
      taps.pin = I_COUNT_PIN & ~pin_reg;
   end

   tick_select u_tick_select (
      .i_sel(control_reg.clk_sel),
      .i_prescaler_select(I_PRESCALER_SELECT),
      .i_slow(I_SLOW_MODE),
      .i_taps(taps),
      .o_tick(sel_tick)
   );

   // lower overflow already carries the lower clock select in 16-bit use
   assign tick = control_reg.mode[2] ? I_LOWER_OVERFLOW : sel_tick;
   assign running = control_reg.run;

   // -------------------------------------------------------------------
   // bus address phase
   // -------------------------------------------------------------------
   assign take = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ);
   assign status_read = take & ~I_HWRITE & (I_HADDR[7:0] == STATUS_OFFSET);

   always_comb begin
      phase_next.valid = take;
      phase_next.write = I_HWRITE;
      phase_next.addr = I_HADDR[ADDR_DECODE_BITS-1:0];
      rdata_next = 32'h0000_0000;
      if (take && !I_HWRITE) begin
         case (I_HADDR[7:0])
            CONTROL_OFFSET: rdata_next = {24'h00_0000, control_reg};
            PERIOD_OFFSET: rdata_next = {24'h00_0000, period_reg};
            PULSE_OFFSET: rdata_next = {24'h00_0000, pulse_reg};
            STATUS_OFFSET: rdata_next = {30'h0000_0000, status_reg};
            MASK_OFFSET: rdata_next = {30'h0000_0000, mask_reg};
            COUNT_OFFSET: rdata_next = {24'h00_0000, count_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // register writes, counter and output flop
   // -------------------------------------------------------------------
   always_comb begin
      control_next = control_reg;
      period_next = period_reg;
      pulse_next = pulse_reg;
      pulse_shadow_next = pulse_shadow_reg;
      count_next = count_reg;
      mask_next = mask_reg;
      flop_next = flop_reg;
      events = '0;

      // counting; nothing moves and no event while stopped
      if (running && tick) begin
         case (control_reg.mode)
            MODE_TIMER8, MODE_TIMER8_ALT, MODE_TIMER16, MODE_WARMUP16: begin
               if (count_reg == period_reg) begin
                  count_next = 8'h00;
                  events[STAT_MATCH_BIT] = 1'b1;
               end else begin
                  count_next = count_reg + 8'h01;
               end
            end
            MODE_DIVIDER8: begin
               if (count_reg == period_reg) begin
                  count_next = 8'h00;
                  flop_next = ~flop_reg;
                  events[STAT_MATCH_BIT] = 1'b1;
               end else begin
                  count_next = count_reg + 8'h01;
               end
            end
            MODE_PWM8, MODE_PWM16: begin
               count_next = count_reg + 8'h01;
               if (count_reg == pulse_shadow_reg) begin
                  flop_next = ~control_reg.preset;
                  events[STAT_MATCH_BIT] = 1'b1;
               end
               if (count_reg == 8'hFF) begin
                  // new width takes effect at the period boundary, or on a start from stopped
                  flop_next = control_reg.preset;
                  pulse_shadow_next = pulse_reg;
                  events[STAT_WRAP_BIT] = 1'b1;
               end
            end
            MODE_PULSE16: begin
               if (count_reg == period_reg) begin
                  count_next = 8'h00;
                  flop_next = control_reg.preset;
                  events[STAT_MATCH_BIT] = 1'b1;
               end else begin
                  count_next = count_reg + 8'h01;
                  if (count_reg == pulse_reg) begin
                     flop_next = ~control_reg.preset;
                  end
               end
            end
            default: count_next = count_reg;
         endcase
      end

      // data phase writes
      if (phase_reg.valid && phase_reg.write) begin
         case (phase_reg.addr)
            CONTROL_OFFSET: begin
               // mode, clock and preset assumed stable unless starting
               control_next = control_type'(I_HWDATA[7:0]);
               if (!I_HWDATA[3]) begin
                  count_next = 8'h00;
               end else if (!control_reg.run) begin
                  count_next = 8'h00;
                  flop_next = I_HWDATA[7];
                  pulse_shadow_next = pulse_reg;
               end
            end
            PERIOD_OFFSET: period_next = I_HWDATA[7:0];
            PULSE_OFFSET: pulse_next = I_HWDATA[7:0];
            MASK_OFFSET: mask_next = I_HWDATA[STAT_WIDTH-1:0];
            default: mask_next = mask_reg;
         endcase
      end

      // a new event outranks the clear-on-read in the same cycle
      status_next = (status_read ? '0 : status_reg) | events;
      irq_next = |(status_next & mask_next);
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         control_reg <= control_type'(CONTROL_RESET);
         period_reg <= PERIOD_RESET;
         pulse_reg <= PULSE_RESET;
         pulse_shadow_reg <= PULSE_RESET;
         count_reg <= 8'h00;
         status_reg <= STATUS_RESET;
         mask_reg <= MASK_RESET;
         flop_reg <= 1'b0;
         irq_reg <= 1'b0;
         phase_reg <= '0;
         rdata_reg <= 32'h0000_0000;
         prescale_reg <= PRESCALE_RESET;
         lf_div_reg <= LF_DIV_RESET;
         pin_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         control_reg <= control_next;
         period_reg <= period_next;
         pulse_reg <= pulse_next;
         pulse_shadow_reg <= pulse_shadow_next;
         count_reg <= count_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         flop_reg <= flop_next;
         irq_reg <= irq_next;
         phase_reg <= phase_next;
         rdata_reg <= rdata_next;
         prescale_reg <= prescale_next;
         lf_div_reg <= lf_div_next;
         pin_reg <= pin_next;
      end
   end

   // -------------------------------------------------------------------
   // fixed bus answers, held in flops so every output is registered
   // -------------------------------------------------------------------
   logic hreadyout_reg;
   logic [1:0] hresp_reg;

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= HRESP_OKAY;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= HRESP_OKAY;
      end
   end

   assign O_HRDATA = rdata_reg;
   assign O_HREADYOUT = hreadyout_reg;
   assign O_HRESP = hresp_reg;
   assign O_IRQ = irq_reg;
   assign O_TIMER_OUT = flop_reg;

endmodule : upper_timer

// [pkg/timer4_pkg.sv]
// Purpose: shared constants and types for the upper cascadable 8-bit timer
// Assumes: 32-bit AHB-Lite register port, one word per register
// Notes: control field layout follows the control byte of the upper timer
package timer4_pkg;

   // -------------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] PERIOD_OFFSET = 8'h04;
   localparam logic [7:0] PULSE_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] MASK_OFFSET = 8'h10;
   localparam logic [7:0] COUNT_OFFSET = 8'h14;
   localparam int ADDR_DECODE_BITS = 8;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] PULSE_RESET = 8'hFF;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [10:0] PRESCALE_RESET = 11'h000;
   localparam logic [2:0] LF_DIV_RESET = 3'h0;

   // -------------------------------------------------------------------
   // status / mask bit positions
   // -------------------------------------------------------------------
   localparam int STAT_MATCH_BIT = 0;
   localparam int STAT_WRAP_BIT = 1;
   localparam int STAT_WIDTH = 2;

   // -------------------------------------------------------------------
   // prescaler tap positions (high_freq_clock / 2^n)
   // -------------------------------------------------------------------
   localparam int TAP_DIV2048 = 11;
   localparam int TAP_DIV128 = 7;
   localparam int TAP_DIV32 = 5;
   localparam int TAP_DIV8 = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      CLK_HF_2048 = 3'b000,
      CLK_HF_128 = 3'b001,
      CLK_HF_32 = 3'b010,
      CLK_HF_8 = 3'b011,
      CLK_LF = 3'b100,
      CLK_HF_2 = 3'b101,
      CLK_HF = 3'b110,
      CLK_PIN = 3'b111
   } clock_select_type;

   typedef enum logic [2:0] {
      MODE_TIMER8 = 3'b000,
      MODE_DIVIDER8 = 3'b001,
      MODE_PWM8 = 3'b010,
      MODE_TIMER8_ALT = 3'b011,
      MODE_TIMER16 = 3'b100,
      MODE_WARMUP16 = 3'b101,
      MODE_PWM16 = 3'b110,
      MODE_PULSE16 = 3'b111
   } mode_type;

   typedef struct packed {
      logic preset;
      clock_select_type clk_sel;
      logic run;
      mode_type mode;
   } control_type;

   typedef struct packed {
      logic hf_2048;
      logic hf_128;
      logic hf_32;
      logic hf_8;
      logic hf_2;
      logic hf;
      logic lf;
      logic lf_8;
      logic pin;
   } taps_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_DECODE_BITS-1:0] addr;
   } bus_phase_type;

endpackage : timer4_pkg
